// >>> rtl/mtr_traffic_reg.sv
// Purpose: traffic regulation of a 10/100 mac (pause frames, back pressure)
// Assumes: one clock, inputs synchronous, classic wishbone slave
// Notes: emits pause and phantom frames as a byte stream to the tx path
// Behaviour
// - forced bits apply when port manager disabled
// - pause in full duplex, back pressure half
// - pause frame carries fixed fields and fcs
// - pause operand sent most significant byte first
// - received pause waits for current frame end
// - back pressure from command or enabled pin
// - matching receive start sends 568-bit phantom
// - back pressure never disturbs own transmission
// - each forced collision bumps counter
// - half duplex ignores received pause frames
// - fixed_length_pause clear: xoff ffff then xon zero
// - fixed_length_pause set: single frame with length register
// - pin ignored while pin enable clear
// - half duplex pin level drives back pressure
// - fixed_length_pause pin: rise sends length, fall nothing
// - xon/xoff pin: rise ffff, fall zero
// - half duplex command bit drives back pressure
// - full duplex command edges send pauses
// - fixed_length_pause clears command bit after trigger
// - pause response forced or negotiated
// - new pause reloads running pause timer
`timescale 1ns/1ps
module mtr_traffic_reg (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // external flow control and station
  input wire logic flow_control_pin_i,
  input wire logic [47:0] station_addr_i,
  // port manager results
  input wire logic an_full_duplex_i,
  input wire logic an_link_i,
  input wire logic [2:0] an_speed_i,
  input wire logic an_partner_pause_i,
  // mac tx and rx status
  input wire logic tx_busy_i,
  input wire logic rx_start_i,
  input wire logic rx_pause_i,
  input wire logic [15:0] rx_pause_operand_i,
  input wire logic slot_tick_i,
  // generated frame byte stream
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  output logic tx_phantom_o,
  input wire logic tx_ready_i,
  // mac configuration and hold
  output logic full_duplex_o,
  output logic link_pass_o,
  output logic [2:0] speed_o,
  output logic tx_hold_o
);

  // sender states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BODY,
    ST_FCS,
    ST_PHANTOM
  } mtr_state_t;

  // every flip-flop of the block
  typedef struct packed {
    logic [31:0] flow;
    logic [31:0] command_register_three;
    logic [2:0] fspeed;
    logic [15:0] plen;
    logic [31:0] bp_cnt;
    logic [31:0] rdat;
    logic ack;
    logic pin;
    logic pend;
    logic [15:0] pend_op;
    logic [15:0] op;
    mtr_state_t st;
    logic [6:0] idx;
    logic [31:0] crc;
    logic [15:0] pause_cnt;
    logic hold;
  } mtr_regs_t;

  mtr_regs_t q;
  mtr_regs_t d;

  // byte-lane write merge
  function automatic logic [31:0] mtr_merge(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction : mtr_merge

  // reflected crc32 over one octet
  function automatic logic [31:0] mtr_crc(input logic [31:0] c,
                                          input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ b[i])
      begin
        r = (r >> 1) ^ mtr_pkg::CRC_POLY;
      end
      else
      begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : mtr_crc

  // pause frame octet by index
  function automatic logic [7:0] mtr_octet(input logic [6:0] i,
                                           input logic [47:0] sa,
                                           input logic [15:0] op);
    logic [7:0] b;
    b = 8'h00; // pad octets are zero
    if (i < 7'h06)
    begin
      b = mtr_pkg::PAUSE_DA[8'(47 - 8*i) -: 8];
    end
    else if (i < 7'h0c)
    begin
      b = sa[8'(47 - 8*(i - 7'h06)) -: 8];
    end
    else
    begin
      case (i)
        7'h0c: b = mtr_pkg::PAUSE_TYPE[15:8];
        7'h0d: b = mtr_pkg::PAUSE_TYPE[7:0];
        7'h0e: b = mtr_pkg::PAUSE_OPCODE[15:8];
        7'h0f: b = mtr_pkg::PAUSE_OPCODE[7:0];
        7'h10: b = op[15:8];
        7'h11: b = op[7:0];
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction : mtr_octet

  // decoded control bits
  logic sw_cmd;
  logic pin_en;
  logic fixed_length_pause;
  logic port_manager_disable;
  logic fd;
  logic bp_en;
  logic resp_en;
  logic wr;
  logic rd_go;
  logic pin_rise;
  logic pin_fall;
  logic cmd_new;
  logic fix_new;
  logic trig;
  logic [15:0] trig_op;
  logic [31:0] fcs;

  // configuration and triggers
  always_comb
  begin
    sw_cmd = q.flow[mtr_pkg::SW_CMD_BIT];
    pin_en = q.flow[mtr_pkg::PIN_EN_BIT];
    fixed_length_pause = q.flow[mtr_pkg::FIXED_LENGTH_PAUSE_BIT];
    port_manager_disable = q.command_register_three[mtr_pkg::PORT_MANAGER_DISABLE_BIT];
    // forced settings replace negotiated ones
    fd = port_manager_disable ? q.command_register_three[mtr_pkg::FORCED_FULL_DUPLEX_BIT] : an_full_duplex_i;
    // pin is dead while its enable is clear
    bp_en = !fd && (sw_cmd || (pin_en && flow_control_pin_i));
    resp_en = fd && (q.flow[mtr_pkg::FPA_BIT]
              || (q.flow[mtr_pkg::NPA_BIT] && an_partner_pause_i));
    // a write lands at the edge where the master sees ack high
    wr = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
    rd_go = wb_cyc_i && wb_stb_i && !q.ack;
    pin_rise = pin_en && flow_control_pin_i && !q.pin;
    pin_fall = pin_en && !flow_control_pin_i && q.pin;
    cmd_new = sw_cmd;
    fix_new = fixed_length_pause;
    if (wr && wb_adr_i == mtr_pkg::FLOW_CTRL_OFS && wb_sel_i[2])
    begin
      cmd_new = wb_dat_i[mtr_pkg::SW_CMD_BIT];
      fix_new = wb_dat_i[mtr_pkg::FIXED_LENGTH_PAUSE_BIT];
    end
    fcs = ~q.crc;
  end

  // pause triggers, full duplex only
  always_comb
  begin
    trig = 1'b0;
    trig_op = mtr_pkg::PAUSE_XON;
    if (fd)
    begin
      if (pin_rise || (cmd_new && !sw_cmd))
      begin
        trig = 1'b1;
        trig_op = fix_new ? q.plen : mtr_pkg::PAUSE_XOFF;
      end
      else if (!fix_new && (pin_fall || (!cmd_new && sw_cmd)))
      begin
        trig = 1'b1;
        trig_op = mtr_pkg::PAUSE_XON;
      end
    end
  end

  // next state of everything
  always_comb
  begin
    d = q;
    d.pin = flow_control_pin_i;
    d.ack = rd_go;
    // register writes
    if (wr)
    begin
      case (wb_adr_i)
        mtr_pkg::FLOW_CTRL_OFS: d.flow = mtr_merge(q.flow, wb_dat_i, wb_sel_i);
        mtr_pkg::COMMAND_REGISTER_THREE_OFS: d.command_register_three = mtr_merge(q.command_register_three, wb_dat_i, wb_sel_i);
        mtr_pkg::CONTROL_REGISTER_TWO_OFS:
        begin
          if (wb_sel_i[2])
          begin
            d.fspeed = wb_dat_i[mtr_pkg::FORCE_SPEED_LSB +: 3];
          end
        end
        mtr_pkg::PAUSE_LEN_OFS:
        begin
          d.plen = 16'(mtr_merge({16'h0000, q.plen}, wb_dat_i, wb_sel_i));
        end
        default: d.rdat = d.rdat; // read-only or unmapped: ignored
      endcase
    end
    // fixed length command clears itself once triggered
    if (fd && fix_new && cmd_new)
    begin
      d.flow[mtr_pkg::SW_CMD_BIT] = 1'b0;
    end
    // latest trigger wins the pending slot
    if (trig)
    begin
      d.pend = 1'b1;
      d.pend_op = trig_op;
    end
    // duplex change drops a stale pause request
    if (!fd)
    begin
      d.pend = 1'b0;
    end
    // frame sender
    case (q.st)
      ST_IDLE:
      begin
        // own frame in flight is never cut short
        if (!tx_busy_i && q.pend && fd)
        begin
          d.pend = trig;
          d.op = q.pend_op;
          d.idx = 7'h00;
          d.crc = mtr_pkg::CRC_INIT;
          d.st = ST_BODY;
        end
        else if (!tx_busy_i && rx_start_i && bp_en)
        begin
          d.idx = 7'h00;
          d.st = ST_PHANTOM;
          d.bp_cnt = q.bp_cnt + 32'h1;
        end
      end
      ST_BODY:
      begin
        if (tx_ready_i)
        begin
          d.crc = mtr_crc(q.crc, mtr_octet(q.idx, station_addr_i, q.op));
          d.idx = q.idx + 7'h01;
          if (q.idx == mtr_pkg::FRAME_BODY_BYTES - 7'h01)
          begin
            d.idx = 7'h00;
            d.st = ST_FCS;
          end
        end
      end
      ST_FCS:
      begin
        if (tx_ready_i)
        begin
          d.idx = q.idx + 7'h01;
          if (q.idx == mtr_pkg::FCS_BYTES - 7'h01)
          begin
            d.st = ST_IDLE;
          end
        end
      end
      ST_PHANTOM:
      begin
        if (tx_ready_i)
        begin
          d.idx = q.idx + 7'h01;
          if (q.idx == mtr_pkg::PHANTOM_BYTES - 7'h01)
          begin
            d.st = ST_IDLE;
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // received pause: reload timer, ignored in half duplex
    if (rx_pause_i && resp_en)
    begin
      d.pause_cnt = rx_pause_operand_i;
    end
    else if (slot_tick_i && q.pause_cnt != 16'h0000 && q.hold)
    begin
      d.pause_cnt = q.pause_cnt - 16'h0001;
    end
    // hold starts only between frames
    if (d.pause_cnt == 16'h0000 || !resp_en)
    begin
      d.hold = 1'b0;
    end
    else if (!tx_busy_i)
    begin
      d.hold = 1'b1;
    end
    // registered read data
    if (rd_go && !wb_we_i)
    begin
      case (wb_adr_i)
        mtr_pkg::FLOW_CTRL_OFS: d.rdat = q.flow;
        mtr_pkg::COMMAND_REGISTER_THREE_OFS: d.rdat = q.command_register_three;
        mtr_pkg::CONTROL_REGISTER_TWO_OFS: d.rdat = {13'h0000, q.fspeed, 16'h0000};
        mtr_pkg::PAUSE_LEN_OFS: d.rdat = {16'h0000, q.plen};
        mtr_pkg::STATUS_OFS:
        begin
          d.rdat = 32'h0000_0000;
          d.rdat[mtr_pkg::ST_PENDING_BIT] = q.pend || q.st == ST_BODY
                                            || q.st == ST_FCS;
          d.rdat[mtr_pkg::ST_PAUSED_BIT] = q.hold;
          d.rdat[mtr_pkg::ST_BP_BIT] = bp_en;
          d.rdat[mtr_pkg::ST_FD_BIT] = fd;
          d.rdat[mtr_pkg::ST_LINK_BIT] = link_pass_o;
          d.rdat[mtr_pkg::ST_RESP_BIT] = resp_en;
        end
        mtr_pkg::BP_COUNT_OFS: d.rdat = q.bp_cnt;
        default: d.rdat = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      q.flow <= mtr_pkg::FLOW_CTRL_RST;
      q.command_register_three <= mtr_pkg::COMMAND_REGISTER_THREE_RST;
      q.fspeed <= mtr_pkg::FORCE_SPEED_RST;
      q.plen <= mtr_pkg::PAUSE_LEN_RST;
      q.bp_cnt <= 32'h0000_0000;
      q.rdat <= 32'h0000_0000;
      q.ack <= 1'b0;
      q.pin <= 1'b0;
      q.pend <= 1'b0;
      q.pend_op <= 16'h0000;
      q.op <= 16'h0000;
      q.st <= ST_IDLE;
      q.idx <= 7'h00;
      q.crc <= mtr_pkg::CRC_INIT;
      q.pause_cnt <= 16'h0000;
      q.hold <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs
  always_comb
  begin
    wb_ack_o = q.ack;
    wb_dat_o = q.rdat;
    full_duplex_o = fd;
    // forced link status puts the mac straight into link pass
    link_pass_o = port_manager_disable ? q.command_register_three[mtr_pkg::FORCE_LINK_BIT] : an_link_i;
    speed_o = port_manager_disable ? q.fspeed : an_speed_i;
    tx_hold_o = q.hold;
    tx_valid_o = q.st != ST_IDLE;
    tx_phantom_o = q.st == ST_PHANTOM;
    tx_byte_o = 8'h00;
    tx_last_o = 1'b0;
    case (q.st)
      ST_BODY: tx_byte_o = mtr_octet(q.idx, station_addr_i, q.op);
      ST_FCS:
      begin
        tx_byte_o = fcs[8*q.idx[1:0] +: 8];
        tx_last_o = q.idx == mtr_pkg::FCS_BYTES - 7'h01;
      end
      ST_PHANTOM:
      begin
        tx_byte_o = mtr_pkg::PHANTOM_PATTERN;
        tx_last_o = q.idx == mtr_pkg::PHANTOM_BYTES - 7'h01;
      end
      default: tx_byte_o = 8'h00;
    endcase
  end

endmodule : mtr_traffic_reg

// >>> inc/mtr_pkg.sv
// Purpose: constants shared by the traffic regulation block
// Assumes: 32-bit classic wishbone, byte addresses
// Notes: field positions are bit numbers inside their register
package mtr_pkg;
  // register byte offsets
  localparam logic [7:0] FLOW_CTRL_OFS = 8'h00;
  localparam logic [7:0] COMMAND_REGISTER_THREE_OFS = 8'h04;
  localparam logic [7:0] CONTROL_REGISTER_TWO_OFS = 8'h08;
  localparam logic [7:0] PAUSE_LEN_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] BP_COUNT_OFS = 8'h14;
  // flow control register fields
  localparam int SW_CMD_BIT = 16;
  localparam int PIN_EN_BIT = 17;
  localparam int FIXED_LENGTH_PAUSE_BIT = 18;
  localparam int NPA_BIT = 19;
  localparam int FPA_BIT = 20;
  // command register three fields
  localparam int PORT_MANAGER_DISABLE_BIT = 14;
  localparam int FORCED_FULL_DUPLEX_BIT = 12;
  localparam int FORCE_LINK_BIT = 11;
  // control register two field
  localparam int FORCE_SPEED_LSB = 16;
  // status register fields
  localparam int ST_PENDING_BIT = 0;
  localparam int ST_PAUSED_BIT = 1;
  localparam int ST_BP_BIT = 2;
  localparam int ST_FD_BIT = 3;
  localparam int ST_LINK_BIT = 4;
  localparam int ST_RESP_BIT = 5;
  // reset values
  localparam logic [31:0] FLOW_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] COMMAND_REGISTER_THREE_RST = 32'h0000_0000;
  localparam logic [2:0] FORCE_SPEED_RST = 3'h0;
  localparam logic [15:0] PAUSE_LEN_RST = 16'h0000;
  // pause frame layout
  localparam logic [47:0] PAUSE_DA = 48'h0180_c200_0001;
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [15:0] PAUSE_XOFF = 16'hffff;
  localparam logic [15:0] PAUSE_XON = 16'h0000;
  localparam logic [6:0] FRAME_BODY_BYTES = 7'h3c;
  localparam logic [6:0] FCS_BYTES = 7'h04;
  // phantom frame: alternating ones and zeros
  localparam int PHANTOM_BITS = 568;
  localparam logic [6:0] PHANTOM_BYTES = 7'(PHANTOM_BITS / 8);
  localparam logic [7:0] PHANTOM_PATTERN = 8'h55;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
endpackage : mtr_pkg

// >>> dv/mtr_traffic_reg_props.sv
// Purpose: port checks for mtr_traffic_reg
// Assumes: one clock, async active high reset
// Notes: bound to the top module after endmodule
`timescale 1ns/1ps
module mtr_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // stream
  input wire logic [7:0] tx_byte_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic tx_phantom_o,
  input wire logic tx_ready_i,
  // mac state
  input wire logic tx_busy_i,
  input wire logic full_duplex_o,
  input wire logic tx_hold_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [6:0] n_q; // bytes taken in frame
  wire logic take = tx_valid_o && tx_ready_i;
  // count restarts after each last byte
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      n_q <= 7'h00;
    else if (take)
      n_q <= tx_last_o ? 7'h00 : n_q + 7'h01;
  end
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence start_s;
    $rose(tx_valid_o);
  endsequence
  ack_one_a: assert property (req_s |=> ack_s)
    else $error("ack not one cycle");
  frame_len_a: assert property (
    take && tx_last_o |-> n_q == (tx_phantom_o ? 7'h46 : 7'h3f))
    else $error("frame length wrong");
  phantom_byte_a: assert property (tx_valid_o && tx_phantom_o |-> tx_byte_o == 8'h55)
    else $error("phantom byte wrong");
  byte_hold_a: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("byte dropped while stalled");
  busy_start_a: assert property (start_s |-> !$past(tx_busy_i))
    else $error("frame started over own frame");
  pause_full_a: assert property ((start_s and !tx_phantom_o) |-> $past(full_duplex_o))
    else $error("pause in half duplex");
  phantom_half_a: assert property ((start_s and tx_phantom_o) |-> !$past(full_duplex_o))
    else $error("phantom in full duplex");
  first_byte_a: assert property ((start_s and !tx_phantom_o) |-> tx_byte_o == 8'h01)
    else $error("pause destination wrong");
  hold_start_a: assert property ($rose(tx_hold_o) |-> !$past(tx_busy_i))
    else $error("hold cut a frame");
endmodule : mtr_props
bind mtr_traffic_reg mtr_props u_props (.core_clk_i, .reset_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .tx_byte_o, .tx_valid_o, .tx_last_o, .tx_phantom_o, .tx_ready_i,
  .tx_busy_i, .full_duplex_o, .tx_hold_o);

// >>> dv/mtr_mii_partner.sv
// Purpose: far side sink of the frame stream
// Assumes: a byte moves when valid and ready meet
// Notes: stalls from an lfsr when asked; reports each frame
`timescale 1ns/1ps
module mtr_mii_partner (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // stream
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  input wire logic tx_phantom_i,
  // control and report
  input wire logic stall_en_i,
  output logic tx_ready_o,
  output logic done_o,
  output logic [23:0] frame_o
);
  logic [6:0] n_q; // bytes taken
  logic [15:0] op_q; // operand octets
  logic [4:0] lf_q; // stall pattern
  // sole enabled phy; stalls test the hold logic
  assign tx_ready_o = !(stall_en_i && lf_q[0]);
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      n_q <= 7'h00;
      op_q <= 16'h0000;
      lf_q <= 5'h15;
      done_o <= 1'b0;
      frame_o <= 24'h0;
    end
    else
    begin
      lf_q <= {lf_q[3:0], lf_q[4] ^ lf_q[2]};
      done_o <= tx_valid_i && tx_ready_o && tx_last_i;
      if (tx_valid_i && tx_ready_o)
      begin
        n_q <= tx_last_i ? 7'h00 : n_q + 7'h01;
        // octet 17 high byte, 18 low
        if (n_q == 7'h10)
          op_q[15:8] <= tx_byte_i;
        if (n_q == 7'h11)
          op_q[7:0] <= tx_byte_i;
        frame_o <= {tx_phantom_i, n_q + 7'h01, op_q};
      end
    end
  end
endmodule : mtr_mii_partner

// >>> dv/tb_mtr_traffic_reg.sv
// Purpose: self-checking bench for mtr_traffic_reg
// Assumes: frame notes are {phantom, bytes, operand}
// Notes: a watcher pops the oldest note per frame
`timescale 1ns/1ps
module tb_mtr_traffic_reg;
  localparam logic [31:0] CMD = 32'h1 << mtr_pkg::SW_CMD_BIT;
  localparam logic [31:0] PIN = 32'h1 << mtr_pkg::PIN_EN_BIT;
  localparam logic [31:0] FIX = 32'h1 << mtr_pkg::FIXED_LENGTH_PAUSE_BIT;
  localparam logic [31:0] NEG = 32'h1 << mtr_pkg::NPA_BIT;
  localparam logic [31:0] FRC = 32'h1 << mtr_pkg::FPA_BIT;
  localparam logic [7:0] FL = mtr_pkg::FLOW_CTRL_OFS;
  localparam logic [7:0] ST = mtr_pkg::STATUS_OFS;
  localparam logic [7:0] BC = mtr_pkg::BP_COUNT_OFS;
  localparam logic [7:0] PL = mtr_pkg::PAUSE_LEN_OFS;
  logic core_clk_i = 1'b0, reset_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, tx_byte_o;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q;
  logic wb_ack_o, flow_control_pin_i = 1'b0, an_full_duplex_i = 1'b1, an_link_i = 1'b1;
  logic an_partner_pause_i = 1'b0, tx_busy_i = 1'b0, rx_start_i = 1'b0, rx_pause_i = 1'b0;
  logic slot_tick_i = 1'b0, stall = 1'b0, done, tx_valid_o, tx_last_o, tx_phantom_o;
  logic tx_ready_i, full_duplex_o, link_pass_o, tx_hold_o;
  logic [47:0] station_addr_i = 48'h0;
  logic [2:0] an_speed_i = 3'h1, speed_o;
  logic [15:0] rx_pause_operand_i = 16'h0, len;
  logic [23:0] frame, q[$];
  int miscompares = 0, compares = 0, n;
  always #10 core_clk_i = ~core_clk_i;
  mtr_traffic_reg DUT (.core_clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .flow_control_pin_i, .station_addr_i,
    .an_full_duplex_i, .an_link_i, .an_speed_i, .an_partner_pause_i, .tx_busy_i,
    .rx_start_i, .rx_pause_i, .rx_pause_operand_i, .slot_tick_i, .tx_byte_o, .tx_valid_o,
    .tx_last_o, .tx_phantom_o, .tx_ready_i, .full_duplex_o, .link_pass_o, .speed_o,
    .tx_hold_o);
  mtr_mii_partner u_far (.core_clk_i, .reset_i, .tx_byte_i(tx_byte_o),
    .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .tx_phantom_i(tx_phantom_o),
    .stall_en_i(stall), .tx_ready_o(tx_ready_i), .done_o(done), .frame_o(frame));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask : wt
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wt(1);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do wt(1); while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask : rd
  // {tick, pause, start} one-cycle strobes
  task automatic sb(input logic [2:0] m);
    wt(1);
    {slot_tick_i, rx_pause_i, rx_start_i} <= m;
    wt(1);
    {slot_tick_i, rx_pause_i, rx_start_i} <= 3'h0;
  endtask : sb
  task automatic pin(input logic v);
    wt(1);
    flow_control_pin_i <= v;
  endtask : pin
  // slot ticks until the hold falls
  task automatic ticks;
    wt(1);
    for (n = 0; n < 20 && tx_hold_o === 1'b1; n++)
    begin
      sb(3'h4);
      wt(2);
    end
  endtask : ticks
  // quiet spell also catches unasked frames
  task automatic drain(input string t);
    for (n = 0; n < 3000 && q.size() != 0; n++)
      wt(1);
    wt(200);
    chk(32'(q.size()), 32'h0);
    $display("test %s done", t);
  endtask : drain
  always @(posedge core_clk_i)
    if (done === 1'b1)
      chk({8'h0, frame}, q.size() != 0 ? {8'h0, q.pop_front()} : 32'hffffffff);
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    #1000000;
    miscompares++;
    wrap_up();
  end
  initial
  begin
    len = 16'($urandom(53870));
    station_addr_i = {16'($urandom), $urandom};
    wt(12);
    reset_i <= 1'b0;
    // reset values, unmapped and read-only places
    rd(FL, mtr_pkg::FLOW_CTRL_RST);
    rd(mtr_pkg::COMMAND_REGISTER_THREE_OFS, mtr_pkg::COMMAND_REGISTER_THREE_RST);
    rd(BC, 32'h0);
    wb(1'b1, 8'h3c, 32'hffffffff);
    wb(1'b1, ST, 32'hffffffff);
    rd(8'h3c, 32'h0);
    rd(ST, 32'h18);
    // forced setup with the port manager off
    an_link_i <= 1'b0;
    wb(1'b1, mtr_pkg::COMMAND_REGISTER_THREE_OFS, 32'h4800);
    wb(1'b1, mtr_pkg::CONTROL_REGISTER_TWO_OFS, 32'h0005_0000);
    wt(1);
    chk({29'h0, speed_o}, 32'h5);
    chk({30'h0, full_duplex_o, link_pass_o}, 32'h1);
    wb(1'b1, mtr_pkg::COMMAND_REGISTER_THREE_OFS, 32'h0);
    an_link_i <= 1'b1;
    an_speed_i <= 3'($urandom);
    stall <= 1'b1;
    wt(1);
    chk({29'h0, speed_o}, {29'h0, an_speed_i});
    drain("regs");
    rd(ST, 32'h18);
    wb_sel_i <= 4'h3;
    wb(1'b1, PL, {16'($urandom), len});
    // lane 2 masked off: the command bit must not move
    wb_sel_i <= 4'h2;
    wb(1'b1, FL, CMD);
    wb_sel_i <= 4'hf;
    rd(PL, {16'h0, len});
    q.push_back({8'h40, len});
    wb(1'b1, FL, FIX | CMD);
    rd(FL, FIX);
    drain("fixed");
    // xoff waits for a busy transmitter
    tx_busy_i <= 1'b1;
    q.push_back(24'h40ffff);
    wb(1'b1, FL, CMD);
    wt(50);
    chk(32'(q.size()), 32'h1);
    tx_busy_i <= 1'b0;
    drain("xoff");
    q.push_back(24'h400000);
    wb(1'b1, FL, 32'h0);
    drain("xon");
    wb(1'b1, FL, PIN | FIX);
    q.push_back({8'h40, len});
    pin(1'b1);
    drain("pin rise fixed");
    pin(1'b0);
    drain("pin fall fixed");
    wb(1'b1, FL, PIN);
    q.push_back(24'h40ffff);
    pin(1'b1);
    drain("pin rise");
    q.push_back(24'h400000);
    pin(1'b0);
    drain("pin fall");
    wb(1'b1, FL, 32'h0);
    pin(1'b1);
    pin(1'b0);
    drain("pin off");
    // back pressure in half duplex
    an_full_duplex_i <= 1'b0;
    wb(1'b1, FL, CMD);
    rd(ST, 32'h14);
    q.push_back(24'hc75555);
    sb(3'h1);
    drain("phantom cmd");
    tx_busy_i <= 1'b1;
    sb(3'h1);
    drain("busy");
    tx_busy_i <= 1'b0;
    wb(1'b1, FL, PIN);
    sb(3'h1);
    pin(1'b1);
    q.push_back(24'hc75555);
    sb(3'h1);
    drain("phantom pin");
    wb(1'b1, FL, FRC);
    sb(3'h1);
    pin(1'b0);
    rx_pause_operand_i <= 16'h0005;
    sb(3'h2);
    wt(4);
    chk({31'h0, tx_hold_o}, 32'h0);
    rd(BC, 32'h2);
    drain("half");
    // pause response, reload and countdown
    an_full_duplex_i <= 1'b1;
    tx_busy_i <= 1'b1;
    rx_pause_operand_i <= 16'h0002;
    sb(3'h2);
    wt(4);
    chk({31'h0, tx_hold_o}, 32'h0);
    tx_busy_i <= 1'b0;
    wt(3);
    chk({31'h0, tx_hold_o}, 32'h1);
    rx_pause_operand_i <= 16'h0005;
    sb(3'h2);
    ticks;
    chk(32'(n), 32'h5);
    wb(1'b1, FL, NEG);
    sb(3'h2);
    wt(4);
    chk({31'h0, tx_hold_o}, 32'h0);
    an_partner_pause_i <= 1'b1;
    sb(3'h2);
    ticks;
    chk(32'(n), 32'h5);
    drain("pause response");
    wrap_up();
  end
endmodule : tb_mtr_traffic_reg
